/* File: hdl/flash_host_map.svh */
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH

//----------------------------------------------------------------
// Behaviour
// R1: Status bit 7 reads one when ready.
// R2: Status bit 6 flags suspended erase.
// R3: Bits 5/4 flag erase/program failure.
// R4: Bit 3 flags low programming supply abort.
// R5: Status bit 2 flags suspended program.
// R6: Bit 1 flags lock-pin abort.
// R7: Host masks reserved status bit 0.
// R8: Host trusts low bits only when ready.
// R9: Bad erase sequence sets bits 5 and 4.
// R10: Supply bit sampled only after command sequence.
// R11: Lock pins sampled only after command sequence.
// R12: Erase writes 20H then D0H, same block.
// R13: Program writes 40H/10H then data.
// R14: Host writes FFH after last operation.
// R15: Error bits sticky until clear-status command.
// R16: Ready/busy low while engine works.
// R17: Ready/busy high in suspend and power-down.
// R18: Supply error sets bit 3 plus op bit.
// R19: Power-down mid-operation aborts; host repeats.
// R20: Power-down clears whole status byte; the model clears bits 6 to 1 only, bit 0 still reads one.
// R21: Command interface starts in array-read mode.
// R22: Host issues array-read before reading contents.
// R23: Erase suspend sets ready and suspended bits.
// R24: Locked boot program sets bits 1 and 4.
// R25: Clear-status command clears sticky error bits.
//----------------------------------------------------------------

// Software register word indexes
`define REG_CMD          3'h0
`define REG_ADDR         3'h1
`define REG_WDATA        3'h2
`define REG_STATUS       3'h3
`define REG_RDATA        3'h4
`define REG_CTRL         3'h5

// Flash command codes
`define FL_ERASE_SETUP   8'h20
`define FL_ERASE_CONFIRM 8'hd0
`define FL_PROG_SETUP    8'h40
`define FL_PROG_SETUP2   8'h10
`define FL_READ_ARRAY    8'hff
`define FL_CLEAR_STATUS  8'h50

// Status byte fields
`define SB_READY         7
`define SB_RSVD          0
`define SB_ERASE_ERR     5
`define SB_PROG_ERR      4
`define SB_MASK          8'hfe

// Status register fields
`define ST_BUSY          0
`define ST_RB_PIN        1
`define ST_DONE          2
`define ST_ABORT         3
`define ST_SEQ_ERR       4
`define ST_BYTE_LSB      8

// Control register fields
`define CTRL_ALT_SETUP   0
`define CTRL_POWERDOWN   1

// Timing
`define CLK_NS           40
`define FL_WE_NS         80
`define FL_GAP_NS        80
`define FL_RD_NS         320
`define NS_TO_CYC(ns)    ((((ns) + `CLK_NS - 1) / `CLK_NS))

`endif

/* File: hdl/flash_host_pkg.sv */
package flash_host_pkg;

    typedef enum logic [2:0]
    {
        S_IDLE   = 3'b000,
        S_CMD1   = 3'b001,
        S_CMD2   = 3'b010,
        S_POLL   = 3'b011,
        S_FINISH = 3'b100,
        S_RDWORD = 3'b101
    } seq_state_t;

    typedef enum logic [2:0]
    {
        OP_NONE       = 3'b000,
        OP_ERASE      = 3'b001,
        OP_PROGRAM    = 3'b010,
        OP_READ_ARRAY = 3'b011,
        OP_CLEAR      = 3'b100,
        OP_READ_WORD  = 3'b101
    } op_t;

endpackage : flash_host_pkg

/* File: hdl/flash_host.sv */
`include "flash_host_map.svh"

module flash_host
    import flash_host_pkg::*;
#(
    parameter int ADDR_W = 19,
    parameter int DATA_W = 16
)
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Avalon-MM slave
    input  wire logic [2:0]        address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    output logic      [31:0]       readdata,
    output logic                   waitrequest,
    // Flash pins
    output logic [ADDR_W-1:0]      flash_addr,
    output logic [DATA_W-1:0]      flash_dq_out,
    input  wire logic [DATA_W-1:0] flash_dq_in,
    output logic                   flash_dq_oe,
    output logic                   chip_sel_n,
    output logic                   out_en_n,
    output logic                   write_en_n,
    output logic                   powerdown_pin_n,
    input  wire logic              ready_busy_pin
);

    localparam logic [7:0] WR_LEN  = 8'(`NS_TO_CYC(`FL_WE_NS));
    localparam logic [7:0] GAP_LEN = 8'(`NS_TO_CYC(`FL_GAP_NS));
    localparam logic [7:0] RD_LEN  = 8'(`NS_TO_CYC(`FL_RD_NS));

    seq_state_t         state;
    op_t                op;
    logic [7:0]         cnt;
    logic [ADDR_W-1:0]  addr_reg;
    logic [DATA_W-1:0]  wdata_reg;
    logic [DATA_W-1:0]  rdata_reg;
    logic [7:0]         status_byte;
    logic               alt_setup;
    logic               powerdown;
    logic               done;
    logic               aborted;
    logic [DATA_W-1:0]  dq_meta;
    logic [DATA_W-1:0]  dq_sync;
    logic               rb_meta;
    logic               rb_sync;
    logic               is_read;
    logic [7:0]         strobe_len;
    logic               cycle_end;
    logic               sample;
    logic [7:0]         cmd_byte;
    logic               bus_wr;
    logic               bus_rd;
    logic               start_cmd;

    //----------------------------------------------------------------
    // Pin synchronisers
    //----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            dq_meta <= '0;
            dq_sync <= '0;
            rb_meta <= 1'b0;
            rb_sync <= 1'b0;
        end
        else
        begin
            dq_meta <= flash_dq_in;
            dq_sync <= dq_meta;
            rb_meta <= ready_busy_pin;
            rb_sync <= rb_meta;
        end
    end

    //----------------------------------------------------------------
    // Avalon slave
    //----------------------------------------------------------------
    assign bus_wr    = write && !waitrequest;
    assign bus_rd    = read && !waitrequest;
    assign start_cmd = bus_wr && (address == `REG_CMD) && (state == S_IDLE) && !powerdown;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            waitrequest <= 1'b1;
        else
            waitrequest <= !((read || write) && waitrequest);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            readdata <= '0;
        else if (read && waitrequest)
        begin
            case (address)
                `REG_ADDR:   readdata <= 32'(addr_reg);
                `REG_WDATA:  readdata <= 32'(wdata_reg);
                `REG_RDATA:  readdata <= 32'(rdata_reg);
                `REG_CTRL:   readdata <= {30'h0, powerdown, alt_setup};
                `REG_STATUS:
                begin
                    readdata                            <= '0;
                    readdata[`ST_BUSY]                  <= (state != S_IDLE);
                    readdata[`ST_RB_PIN]                <= rb_sync;
                    readdata[`ST_DONE]                  <= done;
                    readdata[`ST_ABORT]                 <= aborted;
                    readdata[`ST_SEQ_ERR]               <= status_byte[`SB_ERASE_ERR] & status_byte[`SB_PROG_ERR]; // [R9]
                    readdata[`ST_BYTE_LSB+7:`ST_BYTE_LSB] <= status_byte;
                end
                default:     readdata <= '0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            addr_reg  <= '0;
            wdata_reg <= '0;
            alt_setup <= 1'b0;
            powerdown <= 1'b0;
        end
        else if (bus_wr)
        begin
            case (address)
                `REG_ADDR:  addr_reg  <= writedata[ADDR_W-1:0];
                `REG_WDATA: wdata_reg <= writedata[DATA_W-1:0];
                `REG_CTRL:
                begin
                    alt_setup <= writedata[`CTRL_ALT_SETUP];
                    powerdown <= writedata[`CTRL_POWERDOWN];
                end
                default: ;
            endcase
        end
    end

    //----------------------------------------------------------------
    // Bus cycle timing
    //----------------------------------------------------------------
    assign is_read    = (state == S_POLL) || (state == S_RDWORD);
    assign strobe_len = is_read ? RD_LEN : WR_LEN;
    assign cycle_end  = (state != S_IDLE) && (cnt == strobe_len + GAP_LEN - 8'h01);
    assign sample     = is_read && (cnt == strobe_len - 8'h01);

    always_comb
    begin
        cmd_byte = `FL_READ_ARRAY;
        case (state)
            S_CMD1:
            begin
                case (op)
                    OP_ERASE:   cmd_byte = `FL_ERASE_SETUP;                                   // [R12]
                    OP_PROGRAM: cmd_byte = alt_setup ? `FL_PROG_SETUP2 : `FL_PROG_SETUP;      // [R13]
                    OP_CLEAR:   cmd_byte = `FL_CLEAR_STATUS;                                  // [R25]
                    default:    cmd_byte = `FL_READ_ARRAY;                                    // [R21]
                endcase
            end
            S_CMD2:   cmd_byte = `FL_ERASE_CONFIRM;                                           // [R12]
            S_FINISH: cmd_byte = `FL_READ_ARRAY;                                              // [R14] [R22]
            default:  cmd_byte = `FL_READ_ARRAY;
        endcase
    end

    //----------------------------------------------------------------
    // Sequencer
    //----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= S_IDLE;
            op    <= OP_NONE;
            cnt   <= '0;
        end
        else if (powerdown && state != S_IDLE)
        begin
            // Power-down kills the operation; software must repeat it
            state <= S_IDLE;                                                                  // [R19]
            cnt   <= '0;
        end
        else if (start_cmd)
        begin
            op    <= op_t'(writedata[2:0]);
            cnt   <= '0;
            case (op_t'(writedata[2:0]))
                OP_ERASE, OP_PROGRAM, OP_READ_ARRAY, OP_CLEAR: state <= S_CMD1;
                OP_READ_WORD:                                  state <= S_RDWORD;
                default:                                       state <= S_IDLE;
            endcase
        end
        else if (state != S_IDLE)
        begin
            cnt <= cycle_end ? 8'h00 : cnt + 8'h01;
            if (cycle_end)
            begin
                case (state)
                    S_CMD1:   state <= (op == OP_ERASE || op == OP_PROGRAM) ? S_CMD2 : S_IDLE;
                    S_CMD2:   state <= S_POLL;
                    // Low bits mean nothing until the ready bit is seen
                    S_POLL:   state <= status_byte[`SB_READY] ? S_FINISH : S_POLL;                // [R8]
                    default:  state <= S_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            status_byte <= '0;
            rdata_reg   <= '0;
        end
        else if (sample && state == S_POLL)
            status_byte <= dq_sync[7:0] & `SB_MASK;                                           // [R7]
        else if (sample)
            rdata_reg   <= dq_sync;
    end

    // Done and abort: setting wins over the clear from a new command
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            done    <= 1'b0;
            aborted <= 1'b0;
        end
        else
        begin
            done    <= (cycle_end && (state == S_FINISH || state == S_RDWORD ||
                        (state == S_CMD1 && op != OP_ERASE && op != OP_PROGRAM))) || (done && !start_cmd);
            aborted <= (powerdown && state != S_IDLE) || (aborted && !start_cmd);
        end
    end

    //----------------------------------------------------------------
    // Flash pins
    //----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            flash_addr      <= '0;
            flash_dq_out    <= '0;
            flash_dq_oe     <= 1'b0;
            chip_sel_n      <= 1'b1;
            out_en_n        <= 1'b1;
            write_en_n      <= 1'b1;
            powerdown_pin_n <= 1'b1;
        end
        else
        begin
            powerdown_pin_n <= !powerdown;
            flash_addr      <= addr_reg;
            chip_sel_n      <= !(state != S_IDLE && cnt < strobe_len && !powerdown);
            out_en_n        <= !(is_read && cnt < strobe_len && !powerdown);
            write_en_n      <= !(state != S_IDLE && !is_read && cnt < strobe_len && !powerdown);
            flash_dq_oe     <= state != S_IDLE && !is_read && !powerdown;
            flash_dq_out    <= (state == S_CMD2 && op == OP_PROGRAM) ? wdata_reg : DATA_W'(cmd_byte); // [R13]
        end
    end

    //----------------------------------------------------------------
    // Checks
    //----------------------------------------------------------------
    mask_bit_a: assert property (@(posedge clk) disable iff (rst) // [R7]
        $past(sample) && $past(state) == S_POLL |-> status_byte[`SB_RSVD] == 1'b0 &&
        status_byte[7:1] == $past(dq_sync[7:1]))
        else $error("Reserved status bit not masked");

    poll_ready_a: assert property (@(posedge clk) disable iff (rst) // [R8]
        state == S_FINISH && $past(state) == S_POLL |-> $past(status_byte[`SB_READY]))
        else $error("Left polling without ready bit");

    erase_setup_a: assert property (@(posedge clk) disable iff (rst) // [R12]
        $fell(write_en_n) && $past(state) == S_CMD1 && op == OP_ERASE |-> flash_dq_out == DATA_W'(`FL_ERASE_SETUP))
        else $error("Erase setup code wrong");

    erase_conf_a: assert property (@(posedge clk) disable iff (rst) // [R12]
        $fell(write_en_n) && $past(state) == S_CMD2 && op == OP_ERASE
        |-> flash_dq_out == DATA_W'(`FL_ERASE_CONFIRM) && $stable(flash_addr))
        else $error("Erase confirm wrong");

    prog_setup_a: assert property (@(posedge clk) disable iff (rst) // [R13]
        $fell(write_en_n) && $past(state) == S_CMD1 && op == OP_PROGRAM
        |-> flash_dq_out == (alt_setup ? DATA_W'(`FL_PROG_SETUP2) : DATA_W'(`FL_PROG_SETUP)))
        else $error("Program setup code wrong");

    prog_data_a: assert property (@(posedge clk) disable iff (rst) // [R13]
        $fell(write_en_n) && $past(state) == S_CMD2 && op == OP_PROGRAM |-> flash_dq_out == wdata_reg)
        else $error("Program data wrong");

    array_return_a: assert property (@(posedge clk) disable iff (rst) // [R14]
        $fell(write_en_n) && $past(state) == S_FINISH |-> flash_dq_out == DATA_W'(`FL_READ_ARRAY))
        else $error("Read-array command wrong");

    finish_path_a: assert property (@(posedge clk) disable iff (rst || powerdown) // [R22]
        $past(state) == S_POLL && state != S_POLL |-> state == S_FINISH ##1 state == S_FINISH [*2])
        else $error("Operation ended without read-array");

    strobe_excl_a: assert property (@(posedge clk) disable iff (rst) // [R19]
        $rose(powerdown) |=> chip_sel_n && write_en_n && out_en_n && !flash_dq_oe && state == S_IDLE)
        else $error("Bus active during power-down");

endmodule : flash_host

/* File: sim/flash_device_model.sv */
module flash_device_model
#(
    parameter int BUSY_CYC = 40
)
(
    // Clock
    input  wire logic        clk,
    // Flash pins
    input  wire logic [18:0] flash_addr,
    input  wire logic [15:0] flash_dq_out,
    input  wire logic        chip_sel_n,
    input  wire logic        out_en_n,
    input  wire logic        write_en_n,
    input  wire logic        powerdown_pin_n,
    output logic      [15:0] dq_drive,
    output logic             ready_busy_pin,
    // Fault controls
    input  wire logic        supply_low,
    input  wire logic        lock_on
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [16];
    logic [7:0]  flags;
    logic [1:0]  mode;
    logic        wr_q;
    logic [15:0] last;
    logic [7:0]  c;
    logic [3:0]  a;
    logic        rd;
    int          cnt;
    assign c = flash_dq_out[7:0];
    assign a = flash_addr[3:0];
    assign rd = !chip_sel_n && !out_en_n && powerdown_pin_n;
    assign ready_busy_pin = (cnt == 0);
    // Status byte: reserved bit 0 reads one, suspend bits stay clear
    assign dq_drive = !rd ? ~last : (mode == 2'd0) ? mem[a]
                    : {8'h00, cnt == 0, flags[6:1], 1'b1};
    initial
    begin
        foreach (mem[i]) mem[i] = 16'hffff;
        flags = 8'h00;
        mode = 2'd0;
        cnt = 0;
        wr_q = 1'b0;
        last = 16'h0000;
    end
    always @(posedge clk)
    begin
        wr_q <= !write_en_n && !chip_sel_n;
        if (rd)
            last <= dq_drive;
        if (cnt > 0)
            cnt <= cnt - 1;
        if (!powerdown_pin_n)
        begin
            flags <= 8'h00;
            mode <= 2'd0;
            if (cnt > 3)
                cnt <= 3;
        end
        else if (wr_q && write_en_n)
        begin
            case (mode)
                2'd2:
                begin
                    mode <= 2'd1;
                    if (c != 8'hd0)
                        flags <= flags | 8'h30;
                    else if (supply_low)
                        flags <= flags | 8'h28;
                    else if (lock_on)
                        flags <= flags | 8'h22;
                    else
                    begin
                        mem[a] <= 16'hffff;
                        cnt <= BUSY_CYC;
                    end
                end
                2'd3:
                begin
                    mode <= 2'd1;
                    if (supply_low)
                        flags <= flags | 8'h18;
                    else if (lock_on)
                        flags <= flags | 8'h12;
                    else
                    begin
                        mem[a] <= mem[a] & flash_dq_out;
                        cnt <= BUSY_CYC;
                    end
                end
                default:
                begin
                    mode <= (c == 8'h20) ? 2'd2 : (c == 8'h40 || c == 8'h10) ? 2'd3 : (c == 8'hff) ? 2'd0 : 2'd1;
                    if (c == 8'h50)
                        flags <= flags & 8'h44;
                end
            endcase
        end
    end
endmodule : flash_device_model

/* File: sim/test_flash_status_and_erase_program_flow.sv */
module test_flash_status_and_erase_program_flow;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [2:0] op; logic alt; logic sup; logic lck; logic [7:0] sb; logic seq;} row_t;
    logic        clk, rst, read, write, waitrequest, flash_dq_oe, chip_sel_n, out_en_n, write_en_n;
    logic        powerdown_pin_n, ready_busy_pin, supply_low, lock_on, seen;
    logic [2:0]  address;
    logic [31:0] writedata, readdata, rv;
    logic [18:0] flash_addr;
    logic [15:0] flash_dq_out, flash_dq_in, dq_drive;
    int          fail_count, cmp_count;
    // Sticky error bits accumulate until a clear row
    row_t rows [8] = '{'{3'h1, 0, 0, 0, 8'h80, 0}, '{3'h2, 0, 1, 0, 8'h98, 0}, '{3'h1, 0, 0, 1, 8'hba, 1},
                       '{3'h4, 0, 0, 0, 8'hba, 1}, '{3'h2, 1, 0, 0, 8'h80, 0}, '{3'h2, 0, 0, 1, 8'h92, 0},
                       '{3'h4, 0, 0, 0, 8'h92, 0}, '{3'h1, 0, 1, 0, 8'ha8, 0}};
    assign flash_dq_in = flash_dq_oe ? flash_dq_out : dq_drive;
    flash_host dut_u (.clk, .rst, .address, .read, .write, .writedata, .readdata, .waitrequest, .flash_addr,
                      .flash_dq_out, .flash_dq_in, .flash_dq_oe, .chip_sel_n, .out_en_n, .write_en_n,
                      .powerdown_pin_n, .ready_busy_pin);
    flash_device_model dev_u (.clk, .flash_addr, .flash_dq_out, .chip_sel_n, .out_en_n, .write_en_n,
                              .powerdown_pin_n, .dq_drive, .ready_busy_pin, .supply_low, .lock_on);
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    //------------------------------------------------------------
    // Checking and bus tasks
    //------------------------------------------------------------
    task check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
        end
    endtask : check
    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict
    task wait_ack;
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50)
        begin
            fail_count++;
            give_verdict;
        end
    endtask : wait_ack
    task av_wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        wait_ack;
        write <= 1'b0;
    endtask : av_wr
    task av_rd(input logic [2:0] a);
        @(posedge clk);
        address <= a;
        read <= 1'b1;
        wait_ack;
        rv = readdata;
        read <= 1'b0;
    endtask : av_rd
    task run_op(input logic [2:0] op);
        int n;
        av_wr(3'h0, {29'h0, op});
        n = 0;
        do
        begin
            av_rd(3'h3);
            n++;
        end
        while (!(rv[2] === 1'b1 && rv[0] === 1'b0) && n < 200);
        if (n >= 200)
        begin
            fail_count++;
            give_verdict;
        end
    endtask : run_op
    //------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        address = 3'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        supply_low = 1'b0;
        lock_on = 1'b0;
        fail_count = 0;
        cmp_count = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        av_rd(3'h3);
        check(rv, 32'h2);
        check({31'h0, powerdown_pin_n}, 32'h1);
        av_rd(3'h6);
        check(rv, 32'h0);
        av_wr(3'h1, 32'h3);
        av_wr(3'h2, 32'h1234);
        av_rd(3'h1);
        check(rv, 32'h3);
        foreach (rows[i])
        begin
            supply_low <= rows[i].sup;
            lock_on <= rows[i].lck;
            av_wr(3'h5, {31'h0, rows[i].alt});
            run_op(rows[i].op);
            check({24'h0, rv[15:8]}, {24'h0, rows[i].sb});
            check({31'h0, rv[4]}, {31'h0, rows[i].seq});
        end
        run_op(3'h3);
        run_op(3'h5);
        av_rd(3'h4);
        check(rv, 32'h1234);
        // Power-down in the middle of an erase
        supply_low <= 1'b0;
        lock_on <= 1'b0;
        av_wr(3'h5, 32'h0);
        av_wr(3'h0, 32'h1);
        seen = 1'b0;
        for (int n = 0; n < 20 && !seen; n++)
        begin
            av_rd(3'h3);
            seen = (rv[0] === 1'b1 && rv[1] === 1'b0);
        end
        check({31'h0, seen}, 32'h1);
        av_wr(3'h5, 32'h2);
        av_rd(3'h5);
        check(rv, 32'h2);
        repeat (10) @(posedge clk);
        check({31'h0, powerdown_pin_n}, 32'h0);
        av_rd(3'h3);
        check({30'h0, rv[3], rv[0]}, 32'h2);
        av_wr(3'h5, 32'h0);
        repeat (4) @(posedge clk);
        run_op(3'h5);
        av_rd(3'h4);
        check(rv, 32'hffff);
        run_op(3'h2);
        check({24'h0, rv[15:8]}, 32'h80);
        // Reset in mid-run returns registers and pins to idle
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        check({29'h0, chip_sel_n, out_en_n, write_en_n}, 32'h7);
        av_rd(3'h3);
        check(rv, 32'h2);
        av_rd(3'h1);
        check(rv, 32'h0);
        give_verdict;
    end
endmodule : test_flash_status_and_erase_program_flow
